// [core/sysctl_pkg.sv]
// Package of register map, field layout, reset values and timing for the system clock and reset control.
// Operation
// R1: Three oscillator calibration modes: reference, factory restore, manual trim.
// R2: Reference calibration counts against 32 kHz, only with hibernation unit and clock enabled.
// R3: Factory mode restores the manufacture trim, discarding earlier trims.
// R4: Manual trim takes 7 low bits; 0x40 is nominal 16 MHz.
// R5: Trim above 0x40 slows the oscillator, below 0x40 speeds it.
// R6: Calibration reports 1 on success, 0 on failure.
// R7: PWM clock divides processor clock by 1..64 in powers of two; readable back.
// R8: PWM clock follows the system clock, so its rate tracks clock changes.
// R9: Software reset resets processor, peripherals and registers except reset cause.
// R10: Software reset keeps existing cause flags and sets the software flag.
// R11: Six cause flags: regulator, software, watchdog, brownout, power-on, external pin.
// R12: Cause flags stay set until cleared by software or power-on reset.
// R13: Software clears cause flags by mask; later same reset sets it again.
// R14: Software should clear all causes after reading them.
// R15: With sleep gating on, only sleep-enabled peripherals clocked; otherwise all run.
// R16: USB PLL off leaves USB registers accessible, physical layer stopped.
// R17: Software powers up the USB PLL before any USB connection.
// R18: With gating off, sleep enables are kept but have no effect.
// R19: Calibration result valid only after finish, stable until next request.
package sysctl_pkg;
  // ********************************************************************
  // Register offsets (word addresses).
  // ********************************************************************
  localparam logic [3:0] off_cal_ctrl = 4'h0;
  localparam logic [3:0] off_cal_stat = 4'h1;
  localparam logic [3:0] off_pwm_div = 4'h2;
  localparam logic [3:0] off_swreset = 4'h3;
  localparam logic [3:0] off_cause = 4'h4;
  localparam logic [3:0] off_cause_clr = 4'h5;
  localparam logic [3:0] off_sleep_ctrl = 4'h6;
  localparam logic [3:0] off_sleep_en = 4'h7;
  localparam logic [3:0] off_usb_pll = 4'h8;
  localparam logic [3:0] off_int_stat = 4'h9;
  localparam logic [3:0] off_int_mask = 4'ha;
  localparam int addr_lsb = 2;
  // ********************************************************************
  // Field layout and values.
  // ********************************************************************
  localparam logic [1:0] cal_mode_reference = 2'h1;
  localparam logic [1:0] cal_mode_factory = 2'h2;
  localparam logic [1:0] cal_mode_manual_trim = 2'h3;
  localparam int cal_mode_lsb = 8;
  localparam int cal_start_bit = 31;
  localparam int trim_w = 7;
  localparam logic [6:0] trim_nominal = 7'h40;
  localparam logic [2:0] pwm_clk_div_one = 3'h0;
  localparam logic [2:0] pwm_clk_div_sixtyfour = 3'h6;
  localparam logic [31:0] swreset_key = 32'h0000_0001;
  localparam int cause_regulator_fault = 5;
  localparam int cause_software_request = 4;
  localparam int cause_watchdog = 3;
  localparam int cause_brownout = 2;
  localparam int cause_power_on = 1;
  localparam int cause_external_pin = 0;
  localparam int n_periph = 16;
  localparam int int_cal_done = 0;
  localparam int int_cal_fail = 1;
  // ********************************************************************
  // Timing.
  // ********************************************************************
  localparam int clk_hz = 20_000_000;
  localparam int ref_hz = 32_768;
  localparam int osc_hz = 16_000_000;
  localparam int ref_window_edges = 8;
  // Expected oscillator cycles in the measurement window.
  localparam int expect_count = osc_hz / ref_hz * ref_window_edges;
  localparam int count_tol = 64;
  localparam int cal_timeout_cycles = clk_hz / ref_hz * (ref_window_edges + 2);
  localparam int swreset_pulse_cycles = 4;
endpackage : sysctl_pkg

// [core/system_clock_reset_control.sv]
// System clock, calibration, reset-cause and sleep control block with an Avalon-MM slave.
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module system_clock_reset_control #(
  parameter logic [6:0] factory_trim = 7'h40,
  parameter int cal_timeout = sysctl_pkg::cal_timeout_cycles
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic por_event,
  input wire logic brownout_event,
  input wire logic watchdog_event,
  input wire logic regulator_event,
  input wire logic ext_pin_event,
  input wire logic hib_present,
  input wire logic hib_enabled,
  input wire logic hib_rtc_enabled,
  input wire logic ref_clk_32k,
  input wire logic osc_tick,
  input wire logic sleeping,
  output logic [6:0] osc_trim,
  output logic pwm_clk_en,
  output logic sw_reset_out,
  output logic [15:0] periph_clk_run,
  output logic usb_pll_on,
  output logic usb_phy_active
);
  // ********************************************************************
  // Pin synchronisers and system reset.
  // ********************************************************************
  logic [1:0] ref_sync;
  logic [1:0] tick_sync;
  logic ref_last;
  logic [5:0] ev_s1;
  logic [5:0] ev_s2;
  logic [2:0] sw_cnt;
  logic soft_rst;
  logic [5:0] ev_last;
  always_ff @(posedge clk_sys) begin
    ref_sync <= {ref_sync[0], ref_clk_32k};
    tick_sync <= {tick_sync[0], osc_tick};
    ref_last <= ref_sync[1];
    ev_s1 <= {regulator_event, 1'b0, watchdog_event, brownout_event, por_event, ext_pin_event};
    ev_s2 <= ev_s1;
    ev_last <= ev_s2;
  end
  wire ref_rise = ref_sync[1] & ~ref_last;
  wire [5:0] ev_rise = ev_s2 & ~ev_last;
  wire wr = write & ~waitrequest;
  // A software reset clears all state but the cause register, the bus handshake, read data, synchronisers and its own pulse counter. [R9]
  wire blk_rst = reset | soft_rst;
  // ********************************************************************
  // Bus handshake: every access gets one wait cycle.
  // ********************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
    end
  end
  // ********************************************************************
  // Software reset pulse.
  // ********************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sw_cnt <= 3'h0;
      soft_rst <= 1'b0;
    end else if (wr && address == sysctl_pkg::off_swreset && writedata == sysctl_pkg::swreset_key) begin
      sw_cnt <= 3'(sysctl_pkg::swreset_pulse_cycles);
      soft_rst <= 1'b1; // [R9]
    end else if (sw_cnt != 3'h0) begin
      sw_cnt <= sw_cnt - 3'h1;
      soft_rst <= (sw_cnt != 3'h1);
    end
  end
  assign sw_reset_out = soft_rst;
  // ********************************************************************
  // Reset-cause flags. Only the block reset leaves them; power-on clears.
  // ********************************************************************
  logic [5:0] cause;
  wire clr_sel = wr && address == sysctl_pkg::off_cause_clr;
  always_ff @(posedge clk_sys) begin
    if (reset && ev_s2[sysctl_pkg::cause_power_on]) begin
      cause <= 6'h02; // [R12]
    end else begin
      // A cause arriving with its clear wins over the clear. [R13]
      cause <= (cause & ~(clr_sel ? writedata[5:0] : 6'h00)) | ev_rise
        | {1'b0, (sw_cnt == 3'(sysctl_pkg::swreset_pulse_cycles)), 4'h0}; // [R10] [R11]
    end
  end
  // ********************************************************************
  // Calibration engine.
  // ********************************************************************
  typedef enum logic [1:0] {cal_idle = 2'b00, cal_wait = 2'b01, cal_meas = 2'b11} cal_state_e;
  cal_state_e cal_state;
  logic [15:0] osc_cnt;
  logic [3:0] edge_cnt;
  logic [15:0] tmo;
  logic cal_ok;
  logic cal_done;
  logic ev_done;
  logic ev_fail;
  wire cal_req = wr && address == sysctl_pkg::off_cal_ctrl && writedata[sysctl_pkg::cal_start_bit];
  wire [1:0] req_mode = writedata[sysctl_pkg::cal_mode_lsb +: 2];
  wire hib_ok = hib_present & hib_enabled & hib_rtc_enabled;
  wire [15:0] cnt_lo = 16'(sysctl_pkg::expect_count - sysctl_pkg::count_tol);
  wire [15:0] cnt_hi = 16'(sysctl_pkg::expect_count + sysctl_pkg::count_tol);
  function automatic logic [6:0] trim_step(input logic [6:0] t, input logic slower);
    // Higher trim slows the oscillator, so a slow part needs a lower code. [R5]
    trim_step = slower ? ((t == 7'h00) ? t : t - 7'h1) : ((t == 7'h7f) ? t : t + 7'h1);
  endfunction : trim_step
  always_ff @(posedge clk_sys) begin
    if (blk_rst) begin
      cal_state <= cal_idle;
      osc_trim <= factory_trim;
      cal_ok <= 1'b0;
      cal_done <= 1'b0;
      ev_done <= 1'b0;
      ev_fail <= 1'b0;
      osc_cnt <= 16'h0;
      edge_cnt <= 4'h0;
      tmo <= 16'h0;
    end else begin
      ev_done <= 1'b0;
      ev_fail <= 1'b0;
      case (cal_state)
        cal_idle: begin
          if (cal_req) begin
            cal_done <= 1'b0; // [R19]
            case (req_mode) // [R1]
              sysctl_pkg::cal_mode_factory: begin
                osc_trim <= factory_trim; // [R3]
                cal_ok <= 1'b1;
                cal_done <= 1'b1;
                ev_done <= 1'b1;
              end
              sysctl_pkg::cal_mode_manual_trim: begin
                osc_trim <= writedata[sysctl_pkg::trim_w-1:0]; // [R4]
                cal_ok <= 1'b1;
                cal_done <= 1'b1;
                ev_done <= 1'b1;
              end
              sysctl_pkg::cal_mode_reference: begin
                if (hib_ok) begin
                  cal_state <= cal_wait; // [R2]
                  tmo <= 16'(cal_timeout);
                end else begin
                  cal_ok <= 1'b0; // [R6]
                  cal_done <= 1'b1;
                  ev_fail <= 1'b1;
                end
              end
              default: begin
                cal_ok <= 1'b0;
                cal_done <= 1'b1;
                ev_fail <= 1'b1;
              end
            endcase
          end
        end
        cal_wait: begin
          tmo <= tmo - 16'h1;
          if (ref_rise) begin
            cal_state <= cal_meas;
            osc_cnt <= 16'h0;
            edge_cnt <= 4'h0;
          end else if (tmo == 16'h0) begin
            // A stale success from an earlier request must not survive a timeout. [R6]
            cal_state <= cal_idle;
            cal_ok <= 1'b0;
            cal_done <= 1'b1;
            ev_fail <= 1'b1;
          end
        end
        cal_meas: begin
          tmo <= tmo - 16'h1;
          if (tick_sync[1]) begin
            osc_cnt <= osc_cnt + 16'h1;
          end
          if (ref_rise) begin
            edge_cnt <= edge_cnt + 4'h1;
          end
          if (ref_rise && edge_cnt == 4'(sysctl_pkg::ref_window_edges - 1)) begin
            cal_state <= cal_idle;
            cal_done <= 1'b1;
            if (osc_cnt < cnt_lo || osc_cnt > cnt_hi) begin
              osc_trim <= trim_step(osc_trim, osc_cnt < cnt_lo); // [R2]
            end
            cal_ok <= 1'b1; // [R6]
            ev_done <= 1'b1;
          end else if (tmo == 16'h0) begin
            cal_state <= cal_idle;
            cal_ok <= 1'b0;
            cal_done <= 1'b1;
            ev_fail <= 1'b1;
          end
        end
        default: cal_state <= cal_idle;
      endcase
    end
  end
  // ********************************************************************
  // PWM clock divider.
  // ********************************************************************
  logic [2:0] pwm_div;
  logic [5:0] pwm_cnt;
  always_ff @(posedge clk_sys) begin
    if (blk_rst) begin
      pwm_div <= sysctl_pkg::pwm_clk_div_one;
    end else if (wr && address == sysctl_pkg::off_pwm_div && writedata[2:0] <= sysctl_pkg::pwm_clk_div_sixtyfour) begin
      pwm_div <= writedata[2:0]; // [R7]
    end
  end
  // The divider counts system clock cycles, so its rate follows the system clock. [R8]
  wire [5:0] pwm_last = 6'((7'h01 << pwm_div) - 7'h01);
  always_ff @(posedge clk_sys) begin
    if (blk_rst) begin
      pwm_cnt <= 6'h0;
      pwm_clk_en <= 1'b0;
    end else begin
      pwm_cnt <= (pwm_cnt >= pwm_last) ? 6'h0 : pwm_cnt + 6'h1;
      pwm_clk_en <= (pwm_cnt >= pwm_last); // [R7]
    end
  end
  // ********************************************************************
  // Sleep gating and USB PLL.
  // ********************************************************************
  logic gating_on;
  logic [15:0] sleep_en;
  always_ff @(posedge clk_sys) begin
    if (blk_rst) begin
      gating_on <= 1'b0;
      sleep_en <= 16'h0;
      usb_pll_on <= 1'b0;
    end else if (wr) begin
      if (address == sysctl_pkg::off_sleep_ctrl) begin
        gating_on <= writedata[0];
      end else if (address == sysctl_pkg::off_sleep_en) begin
        sleep_en <= writedata[15:0]; // [R18]
      end else if (address == sysctl_pkg::off_usb_pll) begin
        usb_pll_on <= writedata[0]; // [R17]
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (blk_rst) begin
      periph_clk_run <= 16'hffff;
      usb_phy_active <= 1'b0;
    end else begin
      periph_clk_run <= (sleeping && gating_on) ? sleep_en : 16'hffff; // [R15] [R18]
      usb_phy_active <= usb_pll_on; // [R16]
    end
  end
  // ********************************************************************
  // Interrupt status, cleared by reading it.
  // ********************************************************************
  logic [1:0] int_stat;
  logic [1:0] int_mask;
  wire stat_rd = read && ~waitrequest && address == sysctl_pkg::off_int_stat;
  always_ff @(posedge clk_sys) begin
    if (blk_rst) begin
      int_stat <= 2'h0;
      int_mask <= 2'h0;
      irq <= 1'b0;
    end else begin
      int_stat <= (stat_rd ? 2'h0 : int_stat) | {ev_fail, ev_done};
      if (wr && address == sysctl_pkg::off_int_mask) begin
        int_mask <= writedata[1:0];
      end
      irq <= |(((stat_rd ? 2'h0 : int_stat) | {ev_fail, ev_done}) & int_mask);
    end
  end
  // ********************************************************************
  // Read data.
  // ********************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      readdata <= 32'h0;
    end else if (read && waitrequest) begin
      if (address == sysctl_pkg::off_cal_stat) begin
        readdata <= {23'h0, cal_done, cal_ok, osc_trim}; // [R6]
      end else if (address == sysctl_pkg::off_pwm_div) begin
        readdata <= {29'h0, pwm_div}; // [R7]
      end else if (address == sysctl_pkg::off_cause) begin
        readdata <= {26'h0, cause}; // [R12]
      end else if (address == sysctl_pkg::off_sleep_ctrl) begin
        readdata <= {31'h0, gating_on};
      end else if (address == sysctl_pkg::off_sleep_en) begin
        readdata <= {16'h0, sleep_en};
      end else if (address == sysctl_pkg::off_usb_pll) begin
        readdata <= {31'h0, usb_pll_on};
      end else if (address == sysctl_pkg::off_int_stat) begin
        readdata <= {30'h0, int_stat};
      end else if (address == sysctl_pkg::off_int_mask) begin
        readdata <= {30'h0, int_mask};
      end else begin
        readdata <= 32'h0;
      end
    end
  end
  // ********************************************************************
  // Checks.
  // ********************************************************************
  sequence soft_req_s;
    wr && address == sysctl_pkg::off_swreset && writedata == sysctl_pkg::swreset_key;
  endsequence
  manual_trim_a: assert property (@(posedge clk_sys) disable iff (blk_rst)
    cal_state == cal_idle && cal_req && req_mode == sysctl_pkg::cal_mode_manual_trim
    |=> osc_trim == $past(writedata[6:0]) && cal_ok && cal_done) else $error("manual trim not applied"); // [R4]
  factory_trim_a: assert property (@(posedge clk_sys) disable iff (blk_rst)
    cal_state == cal_idle && cal_req && req_mode == sysctl_pkg::cal_mode_factory
    |=> osc_trim == factory_trim) else $error("factory trim not restored"); // [R3]
  ref_gate_a: assert property (@(posedge clk_sys) disable iff (blk_rst)
    cal_state == cal_idle && cal_req && req_mode == sysctl_pkg::cal_mode_reference && !hib_ok
    |=> cal_state == cal_idle && !cal_ok && cal_done) else $error("reference cal without hibernation"); // [R2]
  result_hold_a: assert property (@(posedge clk_sys) disable iff (blk_rst)
    cal_done && !cal_req |=> $stable(cal_ok)) else $error("result changed without request"); // [R19]
  soft_cause_a: assert property (@(posedge clk_sys) disable iff (reset)
    soft_req_s ##1 1 |=> cause[sysctl_pkg::cause_software_request]) else $error("software cause not set"); // [R10]
  cause_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
    !clr_sel |=> (cause & $past(cause)) == $past(cause)) else $error("cause flag lost"); // [R12]
  soft_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
    soft_req_s |=> soft_rst [*3]) else $error("software reset too short"); // [R9]
  sleep_gate_a: assert property (@(posedge clk_sys) disable iff (blk_rst)
    !gating_on && !$past(gating_on) |=> periph_clk_run == 16'hffff) else $error("gating off yet clocks stopped"); // [R18]
endmodule : system_clock_reset_control
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the system clock, calibration, reset-cause and sleep control block.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
  localparam logic [6:0] ft = 7'h45;
  typedef struct packed {logic [3:0] addr; logic [31:0] wdata; logic [31:0] rexp; int npulse;} row_s;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic [5:0] evt = 6'h02;
  logic hib_present = 1'b0;
  logic hib_enabled = 1'b0;
  logic hib_rtc_enabled = 1'b0;
  logic ref_clk_32k = 1'b0;
  logic osc_tick = 1'b0;
  logic sleeping = 1'b0;
  logic [6:0] osc_trim;
  logic pwm_clk_en;
  logic sw_reset_out;
  logic [15:0] periph_clk_run;
  logic usb_pll_on;
  logic usb_phy_active;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] q;
  int n;
  // ******************************************************************
  // Ordinary register cases: write, read back, and for the divider the pulses seen in 64 cycles.
  // ******************************************************************
  row_s rows [13] = '{
    '{sysctl_pkg::off_pwm_div, 32'h0, 32'h0, 64}, '{sysctl_pkg::off_pwm_div, 32'h1, 32'h1, 32},
    '{sysctl_pkg::off_pwm_div, 32'h2, 32'h2, 16}, '{sysctl_pkg::off_pwm_div, 32'h3, 32'h3, 8},
    '{sysctl_pkg::off_pwm_div, 32'h4, 32'h4, 4}, '{sysctl_pkg::off_pwm_div, 32'h5, 32'h5, 2},
    '{sysctl_pkg::off_pwm_div, 32'h6, 32'h6, 1}, '{sysctl_pkg::off_pwm_div, 32'h7, 32'h6, 1},
    '{sysctl_pkg::off_sleep_en, 32'h0000_00a5, 32'h0000_00a5, -1},
    '{sysctl_pkg::off_sleep_ctrl, 32'h1, 32'h1, -1}, '{sysctl_pkg::off_usb_pll, 32'h1, 32'h1, -1},
    '{sysctl_pkg::off_int_mask, 32'h3, 32'h3, -1}, '{4'hf, 32'h1234_5678, 32'h0, -1}};

  system_clock_reset_control #(.factory_trim(ft), .cal_timeout(200)) dut (
    .clk_sys(clk_sys), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .por_event(evt[sysctl_pkg::cause_power_on]), .brownout_event(evt[sysctl_pkg::cause_brownout]),
    .watchdog_event(evt[sysctl_pkg::cause_watchdog]), .regulator_event(evt[sysctl_pkg::cause_regulator_fault]),
    .ext_pin_event(evt[sysctl_pkg::cause_external_pin]), .hib_present(hib_present),
    .hib_enabled(hib_enabled), .hib_rtc_enabled(hib_rtc_enabled), .ref_clk_32k(ref_clk_32k),
    .osc_tick(osc_tick), .sleeping(sleeping), .osc_trim(osc_trim), .pwm_clk_en(pwm_clk_en),
    .sw_reset_out(sw_reset_out), .periph_clk_run(periph_clk_run), .usb_pll_on(usb_pll_on),
    .usb_phy_active(usb_phy_active));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // ******************************************************************
  // Bus and helper tasks.
  // ******************************************************************
  task automatic report_and_stop;
    $display("counts: %0d comparisons, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // The request is held until waitrequest is seen low at a rising edge, then released at that edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (waitrequest === 1'b0) break;
    end
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      n_errors++;
      report_and_stop();
    end
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc
  // Events are level pulses long enough to pass the two-flop synchroniser.
  task automatic fire(input int b);
    @(posedge clk_sys);
    evt[b] <= 1'b1;
    cyc(4);
    evt[b] <= 1'b0;
    cyc(4);
  endtask : fire
  task automatic cal(input logic [1:0] mode, input logic [6:0] trim, output logic [31:0] s);
    int i;
    wr(sysctl_pkg::off_cal_ctrl, (32'h1 << sysctl_pkg::cal_start_bit) |
       (32'(mode) << sysctl_pkg::cal_mode_lsb) | 32'(trim));
    for (i = 0; i < 100; i++) begin
      rd(sysctl_pkg::off_cal_stat, s);
      if (s[8] === 1'b1) break;
    end
    if (i == 100) begin
      n_errors++;
      report_and_stop();
    end
  endtask : cal
  task automatic done_test(input string s);
    $display("test %s finished", s);
  endtask : done_test
  // ******************************************************************
  // Main sequence.
  // ******************************************************************
  initial begin
    cyc(12);
    `CHECK(waitrequest, 1'b1)
    `CHECK(osc_trim, ft)
    `CHECK(periph_clk_run, 16'hffff)
    reset <= 1'b0;
    cyc(3);
    evt <= 6'h00;
    cyc(4);
    done_test("reset");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, q);
      `CHECK(q, rows[i].rexp)
      if (rows[i].npulse >= 0) begin
        n = 0;
        repeat (64) begin
          @(posedge clk_sys);
          if (pwm_clk_en === 1'b1) n++;
        end
        `CHECK(n, rows[i].npulse)
      end
    end
    cyc(3);
    `CHECK(usb_pll_on, 1'b1)
    `CHECK(usb_phy_active, 1'b1)
    done_test("registers");
    rd(sysctl_pkg::off_int_stat, q);
    foreach (rows[i]) begin
      if (i < 2) begin
        cal(sysctl_pkg::cal_mode_manual_trim, (i == 0) ? 7'h00 : 7'h7f, q);
        `CHECK(q & 32'h1ff, 32'h180 | ((i == 0) ? 32'h00 : 32'h7f))
        `CHECK(osc_trim, (i == 0) ? 7'h00 : 7'h7f)
      end
    end
    cyc(2);
    `CHECK(irq, 1'b1)
    rd(sysctl_pkg::off_int_stat, q);
    `CHECK(q[sysctl_pkg::int_cal_done], 1'b1)
    cyc(3);
    `CHECK(irq, 1'b0)
    cal(sysctl_pkg::cal_mode_factory, 7'h11, q);
    `CHECK(q & 32'h1ff, 32'h180 | 32'(ft))
    `CHECK(osc_trim, ft)
    wr(sysctl_pkg::off_int_mask, 32'h0);
    rd(sysctl_pkg::off_int_stat, q);
    cal(sysctl_pkg::cal_mode_reference, 7'h00, q);
    `CHECK(q & 32'h180, 32'h100)
    hib_present <= 1'b1;
    hib_enabled <= 1'b1;
    hib_rtc_enabled <= 1'b1;
    cal(sysctl_pkg::cal_mode_manual_trim, 7'h40, q);
    `CHECK(q & 32'h1ff, 32'h1c0)
    cal(sysctl_pkg::cal_mode_reference, 7'h00, q);
    `CHECK(q & 32'h180, 32'h100)
    `CHECK(irq, 1'b0)
    rd(sysctl_pkg::off_int_stat, q);
    `CHECK(q[sysctl_pkg::int_cal_fail], 1'b1)
    done_test("calibration");
    sleeping <= 1'b1;
    cyc(3);
    `CHECK(periph_clk_run, 16'h00a5)
    wr(sysctl_pkg::off_sleep_ctrl, 32'h0);
    cyc(3);
    `CHECK(periph_clk_run, 16'hffff)
    rd(sysctl_pkg::off_sleep_en, q);
    `CHECK(q, 32'h0000_00a5)
    sleeping <= 1'b0;
    wr(sysctl_pkg::off_usb_pll, 32'h0);
    cyc(3);
    `CHECK(usb_phy_active, 1'b0)
    rd(sysctl_pkg::off_usb_pll, q);
    `CHECK(q, 32'h0)
    done_test("sleep_usb");
    rd(sysctl_pkg::off_cause, q);
    `CHECK(q, 32'h02)
    fire(sysctl_pkg::cause_watchdog);
    fire(sysctl_pkg::cause_brownout);
    fire(sysctl_pkg::cause_regulator_fault);
    fire(sysctl_pkg::cause_external_pin);
    rd(sysctl_pkg::off_cause, q);
    `CHECK(q, 32'h2f)
    wr(sysctl_pkg::off_cause_clr, 32'h0a);
    rd(sysctl_pkg::off_cause, q);
    `CHECK(q, 32'h25)
    fire(sysctl_pkg::cause_watchdog);
    rd(sysctl_pkg::off_cause, q);
    `CHECK(q, 32'h2d)
    wr(sysctl_pkg::off_pwm_div, 32'h3);
    wr(sysctl_pkg::off_swreset, sysctl_pkg::swreset_key);
    n = 0;
    repeat (12) begin
      @(posedge clk_sys);
      if (sw_reset_out === 1'b1) n++;
    end
    `CHECK(n, sysctl_pkg::swreset_pulse_cycles)
    rd(sysctl_pkg::off_pwm_div, q);
    `CHECK(q, 32'h0)
    rd(sysctl_pkg::off_cause, q);
    `CHECK(q, 32'h3d)
    wr(sysctl_pkg::off_cause_clr, 32'h3f);
    rd(sysctl_pkg::off_cause, q);
    `CHECK(q, 32'h0)
    fire(sysctl_pkg::cause_watchdog);
    @(posedge clk_sys);
    evt[sysctl_pkg::cause_power_on] <= 1'b1;
    reset <= 1'b1;
    cyc(3);
    reset <= 1'b0;
    cyc(3);
    evt <= 6'h00;
    cyc(4);
    rd(sysctl_pkg::off_cause, q);
    `CHECK(q, 32'h02)
    done_test("reset_cause");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
